/* rtl/hsc_pkg.sv */
// hsc_pkg: constants, states and carriers of the humidity command port
// assumes a 100 MHz core clock and a host that clocks the serial link
package hsc_pkg;

	// ==========================================================
	// core clock and scheduler timing
	localparam int CLK_MHZ = 100;
	localparam int TICK_MS = 1000; // scheduler step: one second
	localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
	localparam int WET_S = 60 * 60; // humid spell before heating
	localparam int GAP_S = 20 * 60; // default heating interval
	localparam int HOLD_S = 5 * 60; // longest hold of old reading
	localparam int HEAT_S = 60; // length of one heating cycle
	localparam logic [15:0] WET_LIMIT = 16'h03b6; // 95.0 percent
	localparam logic [15:0] GAP_RST = 16'(GAP_S);

	// ==========================================================
	// command bytes and fixed answers
	localparam logic [7:0] CMD_MEAS = 8'hc1;
	localparam logic [7:0] CMD_VER = 8'hc2;
	localparam logic [7:0] CMD_HEAT_ON = 8'hd5;
	localparam logic [7:0] CMD_HEAT_OFF = 8'hd6;
	localparam logic [7:0] CMD_TCAL = 8'he5;
	localparam logic [7:0] CMD_HCAL = 8'he6;
	localparam logic [7:0] CMD_UNIT = 8'he7;
	localparam logic [15:0] CK_VER = 16'h0069;
	localparam logic [2:0] MEAS_LAST = 3'h4;
	localparam logic [2:0] VER_LAST = 3'h1;

	// ==========================================================
	// register offsets and status fields
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_SPARE = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_CAL = 8'h0c;
	localparam int STAT_HEAT = 0;
	localparam int STAT_UNIT = 1;
	localparam int STAT_WET = 2;
	localparam int STAT_HOLD = 3;
	localparam int STAT_HUM = 16;

	// ==========================================================
	// serial link framing
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam logic [4:0] WORD_LAST = 5'h0f;

	typedef enum logic [2:0] {
		L_IDLE = 3'h0, L_RX = 3'h1, L_RACK = 3'h3,
		L_TX = 3'h2, L_TACK = 3'h6, L_HOLD = 3'h7
	} hsc_lst_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'h0, M_ARG1 = 3'h1, M_ARG2 = 3'h3,
		M_SEND = 3'h2, M_DONE = 3'h6
	} hsc_mst_t;

	// link events towards the command core, one-cycle pulses
	typedef struct packed {
		logic start;
		logic stop;
		logic rx_valid;
		logic [7:0] rx_byte;
		logic word_ack;
	} hsc_lnk_evt_t;

	// core decisions towards the link, levels
	typedef struct packed {
		logic ack_en;
		logic tx_valid;
		logic [15:0] tx_word;
	} hsc_lnk_tx_t;

endpackage : hsc_pkg

/* rtl/hsc_link.sv */
// hsc_link: bit level of the two-wire link, device side
// assumes the host drives the clock pin and pulls the data pin up
`timescale 1ns/100ps
module hsc_link import hsc_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output logic sda_out,
	output logic sda_oe,
	input hsc_lnk_tx_t tx,
	output hsc_lnk_evt_t evt
);

	typedef struct packed {
		hsc_lst_t st;
		logic [4:0] cnt;
		logic [15:0] sh;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic oe;
		hsc_lnk_evt_t evt;
	} hsc_lstate_t;

	hsc_lstate_t q, n;
	logic rise, fall, sda, start, stop;

	// ==========================================================
	// pin edges, read only behind the second sync stage
	assign rise = q.scl_s[1] & ~q.scl_s[2];
	assign fall = ~q.scl_s[1] & q.scl_s[2];
	assign sda = q.sda_s[1];
	assign start = q.scl_s[1] & q.sda_s[2] & ~sda;
	assign stop = q.scl_s[1] & ~q.sda_s[2] & sda;

	// open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = q.oe;
	assign evt = q.evt;

	// next state; data changes only after a clock fall
	always_comb begin
		n = q;
		n.evt = '0;
		n.scl_s = {q.scl_s[1:0], scl_pin};
		n.sda_s = {q.sda_s[1:0], sda_pin};
		if (start) begin
			// first byte after start is the command, no address byte
			n.st = L_RX;
			n.cnt = '0;
			n.oe = 1'b0;
			n.evt.start = 1'b1;
		end else if (stop) begin
			n.st = L_IDLE;
			n.oe = 1'b0;
			n.evt.stop = 1'b1;
		end else begin
			unique case (q.st)
				L_IDLE, L_HOLD: begin
				end
				L_RX: begin
					if (rise && q.cnt < BYTE_BITS) begin
						n.sh = {q.sh[14:0], sda};
						n.cnt = q.cnt + 5'h1;
						n.evt.rx_valid = (q.cnt == BYTE_BITS - 5'h1);
						n.evt.rx_byte = {q.sh[6:0], sda};
					end else if (fall && q.cnt == BYTE_BITS) begin
						n.oe = tx.ack_en;
						n.st = tx.ack_en ? L_RACK : L_HOLD;
					end
				end
				L_TX: begin
					if (fall) begin
						if (q.cnt == WORD_LAST) begin
							n.oe = 1'b0;
							n.st = L_TACK;
						end else begin
							n.sh = {q.sh[14:0], 1'b0};
							n.oe = ~q.sh[14];
							n.cnt = q.cnt + 5'h1;
						end
					end
				end
				L_RACK, L_TACK: begin
					if (rise && q.st == L_TACK) begin
						// host ack low asks for the next word
						n.evt.word_ack = ~sda;
						if (sda) n.st = L_HOLD;
					end else if (fall) begin
						n.oe = 1'b0;
						n.cnt = '0;
						n.st = (q.st == L_RACK) ? L_RX : L_HOLD;
						if (tx.tx_valid) begin
							n.sh = tx.tx_word;
							n.oe = ~tx.tx_word[15];
							n.st = L_TX;
						end
					end
				end
				default: n.st = L_IDLE;
			endcase
		end
	end

	// sync stages reset to the idle-high level: no false edge after reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
			q.scl_s <= '1;
			q.sda_s <= '1;
		end else begin
			q <= n;
		end
	end

	// ==========================================================
	// checks
	a_word_release: assert property (
		@(posedge clk) disable iff (!rst_n)
		(q.st == L_TX && fall && q.cnt == WORD_LAST) |=>
		(q.st == L_TACK && !q.oe))
		else $error("data pin still driven after sixteen bits");

	a_byte_ack: assert property (
		@(posedge clk) disable iff (!rst_n)
		(q.st == L_RX && fall && q.cnt == BYTE_BITS && tx.ack_en
		&& !start && !stop) |=> (q.oe && q.st == L_RACK) [*1]
		##1 (q.oe throughout (!fall [*1])) or (q.st != L_RACK))
		else $error("received byte not acknowledged");

endmodule : hsc_link

/* rtl/hsc_top.sv */
// hsc_top: command interpreter and heating scheduler of the sensor
// assumes measurements arrive on the core clock; registers over AHB-Lite
//
// Contract
// - words read are 16 bits, bytes written 8
// - 0xC1 then five acked words, then stop
// - first measurement word is a spare word
// - second word: humidity in tenths of percent
// - third word: temperature in tenths, selected unit
// - fourth word: one while heating, else zero
// - fifth word: sum of the four before
// - 0xC2 returns version then 0x69
// - 0xD5 starts heating, answers 0xD5
// - 0xD6 stops heating, answers 0xD6
// - 0xE5 two bytes, answer their sum
// - 0xE6 two bytes, answer their sum
// - 0xE7 byte: 1 Fahrenheit, 0 Celsius
// - humid over an hour: heat every interval
// - hold pre-heat temperature up to five minutes
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module hsc_top import hsc_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter logic [15:0] VERSION_WORD = 16'h0001 // arbitrary value
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output logic sda_out,
	output logic sda_oe,
	output logic heater_on,
	input wire logic [15:0] meas_hum,
	input wire logic [15:0] meas_temp,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);

	typedef struct packed {
		hsc_mst_t st;
		logic [7:0] cmd;
		logic [7:0] hi;
		logic [2:0] idx;
		logic [2:0] last;
		logic [4:0][15:0] words;
		logic ack_en;
		logic tx_valid;
		logic unit;
		logic [15:0] tcal;
		logic [15:0] hcal;
		logic [15:0] gap;
		logic [15:0] spare;
		logic heating;
		logic hold;
		logic [15:0] held;
		logic [15:0] heat_s;
		logic [15:0] wet_s;
		logic [15:0] gap_s;
		logic [15:0] hold_s;
		logic [26:0] tick_cnt;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} hsc_core_t;

	hsc_core_t q, n;
	hsc_lnk_evt_t evt;
	hsc_lnk_tx_t tx;
	logic [15:0] hum_rep, temp_c, temp_now, temp_rep;
	logic tick, wet, go_heat, end_heat;

	// ==========================================================
	// helpers
	function automatic logic [15:0] sum16(input logic [15:0] a,
		input logic [15:0] b);
		return a + b;
	endfunction : sum16

	// tenths of a degree, Celsius to Fahrenheit, signed
	function automatic logic [15:0] to_f(input logic [15:0] c);
		int t;
		t = int'($signed(c)) * 9 / 5 + 320;
		return t[15:0];
	endfunction : to_f

	function automatic logic known(input logic [7:0] b);
		return b inside {CMD_MEAS, CMD_VER, CMD_HEAT_ON, CMD_HEAT_OFF,
			CMD_TCAL, CMD_HCAL, CMD_UNIT};
	endfunction : known

	// ==========================================================
	// reported values: calibration offsets apply to every report
	assign hum_rep = meas_hum + q.hcal;
	assign temp_c = meas_temp + q.tcal;
	assign temp_now = q.hold ? q.held : temp_c;
	assign temp_rep = q.unit ? to_f(temp_now) : temp_now;
	assign tick = (q.tick_cnt == 27'(TICK_CYCLES - 1));
	assign wet = (q.wet_s > 16'(WET_S));

	// link side and outputs
	assign tx.ack_en = q.ack_en;
	assign tx.tx_valid = q.tx_valid;
	assign tx.tx_word = q.words[q.idx];
	assign heater_on = q.heating;
	assign hrdata = q.rdata;
	assign hreadyout = 1'b1; // no wait states ever needed
	assign hresp = 1'b0;

	hsc_link u_link (
		.clk(clk),
		.rst_n(rst_n),
		.scl_pin(scl_pin),
		.sda_pin(sda_pin),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.tx(tx),
		.evt(evt)
	);

	// ==========================================================
	// next state: scheduler, command core, register slave
	always_comb begin
		n = q;
		go_heat = 1'b0;
		end_heat = 1'b0;
		n.tick_cnt = tick ? '0 : q.tick_cnt + 27'h1;

		// one-second steps; wet_s saturates, gap_s restarts, heat_s and hold_s stop, so none wraps
		if (tick) begin
			if (hum_rep > WET_LIMIT) begin
				if (!wet) n.wet_s = q.wet_s + 16'h1;
			end else begin
				n.wet_s = '0;
			end
			if (wet && !q.heating) begin
				n.gap_s = q.gap_s + 16'h1;
				if (n.gap_s >= q.gap) begin
					go_heat = 1'b1;
					n.gap_s = '0;
				end
			end else if (!wet) begin
				n.gap_s = '0;
			end
			if (q.heating) begin
				n.heat_s = q.heat_s + 16'h1;
				if (n.heat_s >= 16'(HEAT_S)) end_heat = 1'b1;
			end
			if (q.hold) n.hold_s = q.hold_s + 16'h1;
		end
		// warm air lingers: keep old reading until cool or timed out
		if (q.hold && (n.hold_s >= 16'(HOLD_S) ||
			(!q.heating && $signed(temp_c) <= $signed(q.held))))
			n.hold = 1'b0;

		// command core
		if (evt.start || evt.stop) begin
			n.st = M_IDLE;
			n.tx_valid = 1'b0;
			n.ack_en = 1'b1;
			n.idx = '0;
		end else if (evt.rx_valid) begin
			unique case (q.st)
				M_IDLE: begin
					n.cmd = evt.rx_byte;
					n.idx = '0;
					n.last = '0;
					n.tx_valid = 1'b1;
					n.st = M_SEND;
					n.words[0] = {8'h00, evt.rx_byte};
					unique case (evt.rx_byte)
						CMD_MEAS: begin
							// snapshot so the checksum matches the words
							n.words[0] = q.spare;
							n.words[1] = hum_rep;
							n.words[2] = temp_rep;
							n.words[3] = {15'h0000, q.heating};
							n.words[4] = sum16(sum16(q.spare, hum_rep),
								sum16(temp_rep, {15'h0000, q.heating}));
							n.last = MEAS_LAST;
						end
						CMD_VER: begin
							n.words[0] = VERSION_WORD;
							n.words[1] = CK_VER;
							n.last = VER_LAST;
						end
						CMD_HEAT_ON: go_heat = 1'b1;
						CMD_HEAT_OFF: end_heat = 1'b1;
						CMD_TCAL, CMD_HCAL, CMD_UNIT: begin
							n.tx_valid = 1'b0;
							n.st = M_ARG1;
						end
						default: begin
							n.tx_valid = 1'b0;
							n.ack_en = 1'b0;
							n.st = M_DONE;
						end
					endcase
				end
				M_ARG1: begin
					n.hi = evt.rx_byte;
					n.st = M_ARG2;
					if (q.cmd == CMD_UNIT) begin
						n.st = M_DONE;
						if (evt.rx_byte == 8'h01) n.unit = 1'b1;
						else if (evt.rx_byte == 8'h00) n.unit = 1'b0;
					end
				end
				M_ARG2: begin
					if (q.cmd == CMD_TCAL) n.tcal = {q.hi, evt.rx_byte};
					else n.hcal = {q.hi, evt.rx_byte};
					n.words[0] = sum16({8'h00, q.hi}, {8'h00, evt.rx_byte});
					n.last = '0;
					n.idx = '0;
					n.tx_valid = 1'b1;
					n.st = M_SEND;
				end
				M_SEND, M_DONE: n.ack_en = 1'b0;
				default: n.st = M_IDLE;
			endcase
		end else if (evt.word_ack && q.st == M_SEND) begin
			if (q.idx == q.last) begin
				n.tx_valid = 1'b0;
				n.st = M_DONE;
			end else begin
				n.idx = q.idx + 3'h1;
			end
		end

		// heater control; a stop in the same cycle wins
		if (go_heat) begin
			if (!q.hold) n.held = temp_c;
			n.hold = 1'b1;
			n.hold_s = '0;
			n.heating = 1'b1;
			n.heat_s = '0;
		end
		if (end_heat) n.heating = 1'b0;

		// register slave: write data lands one cycle after its address
		n.wr_pend = 1'b0;
		if (q.wr_pend) begin
			unique case (q.wr_addr)
				A_CTRL: n.gap = hwdata[15:0];
				A_SPARE: n.spare = hwdata[15:0];
				default: begin
				end
			endcase
		end
		if (hsel && hready && htrans[1]) begin
			n.wr_pend = hwrite;
			n.wr_addr = haddr[7:0];
			n.rdata = '0;
			unique case (haddr[7:0])
				A_CTRL: n.rdata[15:0] = q.gap;
				A_SPARE: n.rdata[15:0] = q.spare;
				A_STAT: begin
					n.rdata[STAT_HEAT] = q.heating;
					n.rdata[STAT_UNIT] = q.unit;
					n.rdata[STAT_WET] = wet;
					n.rdata[STAT_HOLD] = q.hold;
					n.rdata[STAT_HUM +: 16] = hum_rep;
				end
				A_CAL: n.rdata = {q.tcal, q.hcal};
				default: n.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= M_IDLE;
			q.ack_en <= 1'b1;
			q.gap <= GAP_RST;
		end else begin
			q <= n;
		end
	end

	// ==========================================================
	// checks
	a_meas_sum: assert property (
		@(posedge clk) disable iff (!rst_n)
		(q.st == M_SEND && q.cmd == CMD_MEAS) |-> (q.words[4] ==
		sum16(sum16(q.words[0], q.words[1]), sum16(q.words[2], q.words[3]))))
		else $error("measurement checksum wrong");

	a_ver_check: assert property (
		@(posedge clk) disable iff (!rst_n)
		(evt.rx_valid && q.st == M_IDLE && evt.rx_byte == CMD_VER) |=>
		(q.words[0] == VERSION_WORD && q.words[1] == CK_VER && q.tx_valid))
		else $error("version answer wrong");

	a_heat_on: assert property (
		@(posedge clk) disable iff (!rst_n)
		(evt.rx_valid && q.st == M_IDLE && evt.rx_byte == CMD_HEAT_ON)
		|=> (q.heating && q.words[0] == {8'h00, CMD_HEAT_ON}))
		else $error("heat start command not obeyed");

	a_heat_off: assert property (
		@(posedge clk) disable iff (!rst_n)
		(evt.rx_valid && q.st == M_IDLE && evt.rx_byte == CMD_HEAT_OFF)
		|=> (!q.heating && q.words[0] == {8'h00, CMD_HEAT_OFF}))
		else $error("heat stop command not obeyed");

	a_cal_sum: assert property (
		@(posedge clk) disable iff (!rst_n)
		(evt.rx_valid && q.st == M_ARG2) |=> (q.tx_valid && q.words[0] ==
		sum16({8'h00, $past(q.hi)}, {8'h00, $past(evt.rx_byte)})))
		else $error("calibration checksum wrong");

	a_unit_select: assert property (
		@(posedge clk) disable iff (!rst_n)
		(evt.rx_valid && q.st == M_ARG1 && q.cmd == CMD_UNIT &&
		evt.rx_byte == 8'h01) |=> q.unit)
		else $error("Fahrenheit not selected");

	a_hold_capture: assert property (
		@(posedge clk) disable iff (!rst_n)
		($rose(q.heating) && !$past(q.hold)) |->
		(q.hold && q.held == $past(temp_c)))
		else $error("pre-heat temperature not held");

	a_bad_cmd: assert property (
		@(posedge clk) disable iff (!rst_n)
		(evt.rx_valid && q.st == M_IDLE && !known(evt.rx_byte)) |=>
		(!q.ack_en && !q.tx_valid && q.st == M_DONE))
		else $error("unknown command answered");

endmodule : hsc_top

/* tb/hsc_host.sv */
// hsc_host: host side of the two-wire link, clocks the bus and pulls data
// assumes the testbench resolves the data wire with a pull-up
`timescale 1ns/100ps
module hsc_host (
	output logic scl,
	output logic pull,
	input wire logic sda
);
	// ==========================================================
	// bit level: 125 ns per bit, clock stands high between frames
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end

	// data changes well after the clock falls, read mid-way through the high phase
	task automatic xbit(input logic b, output logic r);
		#20 pull = ~b;
		#42.5 scl = 1'b1;
		#31.2 r = sda;
		#31.3 scl = 1'b0;
	endtask : xbit

	task automatic start();
		#62.5 pull = 1'b1; // data falls while clock high
		#62.5 scl = 1'b0;
	endtask : start

	task automatic stop();
		#20 pull = 1'b1;
		#42.5 scl = 1'b1;
		#62.5 pull = 1'b0; // data rises while clock high
		#62.5;
	endtask : stop

	// command or data byte, msb first, then the device's acknowledge
	task automatic send_byte(input logic [7:0] d, output logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) xbit(d[i], r);
		xbit(1'b1, nack);
	endtask : send_byte

	// word from the device; the last one is refused to end the frame
	task automatic get_word(input logic last, output logic [15:0] w);
		logic r;
		for (int i = 15; i >= 0; i--) xbit(1'b1, w[i]);
		xbit(last, r);
	endtask : get_word
endmodule : hsc_host

/* tb/testbench.sv */
// testbench: drives the command port over the link and its registers
// assumes the host model owns the link; the bench owns the register bus
`timescale 1ns/100ps
module testbench import hsc_pkg::*; ;
	logic clk, rst_n, scl, pull, sda, sda_out, sda_oe, heater_on;
	logic hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] meas_hum, meas_temp, sp, hm, tp, tc, hc;
	logic [15:0] w [5];
	logic [7:0] b1, b2, c1, c2;
	integer seed;
	int err_count, num_checks;

	// ==========================================================
	// wire resolution: open drain with pull-up, both parties may pull
	assign sda = (sda_oe ? sda_out : 1'b1) & ~pull;
	hsc_host h (.scl(scl), .pull(pull), .sda(sda));
	hsc_top #(.TICK_CYCLES(20), .VERSION_WORD(16'h0001)) i_dut (
		.clk(clk), .rst_n(rst_n), .scl_pin(scl), .sda_pin(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .heater_on(heater_on),
		.meas_hum(meas_hum), .meas_temp(meas_temp), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp)); // version value is arbitrary

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one single transfer; waits on ready, never on a fixed count
	task automatic ahb(input logic wr, input logic [31:0] a, d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	// one link frame: command, data bytes, then words read back
	task automatic xact(input logic [7:0] c, input int nb,
		input logic [7:0] p, q, input int nw, input logic xn);
		logic n;
		h.start();
		h.send_byte(c, n);
		check(n, xn);
		if (nb > 0) h.send_byte(p, n);
		if (nb > 0) check(n, 1'b0);
		if (nb > 1) h.send_byte(q, n);
		if (nb > 1) check(n, 1'b0);
		for (int i = 0; i < nw; i++) h.get_word(i == nw - 1, w[i]);
		h.stop();
	endtask : xact

	task automatic meas(input logic [15:0] s, m, t, ht);
		xact(CMD_MEAS, 0, 8'h00, 8'h00, 5, 1'b0);
		check(w[0], s);
		check(w[1], m);
		check(w[2], t);
		check(w[3], ht);
		check(w[4], 16'(s + m + t + ht));
	endtask : meas

	function automatic logic [15:0] fahr(input logic [15:0] c);
		return 16'((int'(c) * 9) / 5 + 320);
	endfunction : fahr

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict

	// ==========================================================
	// watchdog: the humid hour alone takes about 72000 cycles
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		print_verdict();
	end

	// ==========================================================
	// main sequence
	initial begin
		seed = 80;
		rst_n = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		meas_hum = 16'h0000;
		meas_temp = 16'h0000;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		ahb(1'b0, {24'h0, A_CTRL}, 32'h0);
		check(rd, 32'h0000_04b0);
		ahb(1'b0, 32'h0000_0040, 32'h0);
		check(rd, 32'h0);
		sp = 16'($random(seed));
		ahb(1'b1, {24'h0, A_SPARE}, {16'h0, sp});
		// readings kept low so the sums never reach the humid limit
		hm = 16'($unsigned($random(seed)) % 400);
		tp = 16'($unsigned($random(seed)) % 400);
		@(posedge clk);
		meas_hum <= hm;
		meas_temp <= tp;
		meas(sp, hm, tp, 16'h0);
		xact(CMD_VER, 0, 8'h00, 8'h00, 2, 1'b0);
		check(w[0], 16'h0001);
		check(w[1], CK_VER);
		// heating on, reading rises, old reading must be reported
		xact(CMD_HEAT_ON, 0, 8'h00, 8'h00, 1, 1'b0);
		check(w[0], 16'h00d5);
		check(heater_on, 1'b1);
		meas_temp <= tp + 16'h0032;
		meas(sp, hm, tp, 16'h1);
		xact(CMD_HEAT_OFF, 0, 8'h00, 8'h00, 1, 1'b0);
		check(w[0], 16'h00d6);
		check(heater_on, 1'b0);
		meas_temp <= tp;
		// small positive offsets keep the unit conversion exact
		b1 = 8'($random(seed)) & 8'h01;
		b2 = 8'($random(seed));
		c1 = 8'($random(seed)) & 8'h01;
		c2 = 8'($random(seed));
		tc = {b1, b2};
		hc = {c1, c2};
		xact(CMD_TCAL, 2, b1, b2, 1, 1'b0);
		check(w[0], 16'(b1) + 16'(b2));
		xact(CMD_HCAL, 2, c1, c2, 1, 1'b0);
		check(w[0], 16'(c1) + 16'(c2));
		ahb(1'b0, {24'h0, A_CAL}, 32'h0);
		check(rd, {tc, hc});
		meas(sp, hm + hc, tp + tc, 16'h0);
		xact(CMD_UNIT, 1, 8'h01, 8'h00, 0, 1'b0);
		meas(sp, hm + hc, fahr(tp + tc), 16'h0);
		xact(CMD_UNIT, 1, 8'h00, 8'h00, 0, 1'b0);
		meas(sp, hm + hc, tp + tc, 16'h0);
		xact(8'haa, 0, 8'h00, 8'h00, 0, 1'b1);
		xact(CMD_VER, 0, 8'h00, 8'h00, 2, 1'b0);
		check(w[1], CK_VER);
		// humid spell: short interval so heating follows the hour closely
		ahb(1'b1, {24'h0, A_CTRL}, 32'h0000_000a);
		ahb(1'b0, {24'h0, A_CTRL}, 32'h0);
		check(rd, 32'h0000_000a);
		meas_hum <= 16'h03c0;
		repeat (3590 * 20) @(posedge clk);
		check(heater_on, 1'b0);
		for (int i = 0; i < 800 && heater_on !== 1'b1; i++) @(posedge clk);
		check(heater_on, 1'b1);
		// status mid-heat: heating, humid, holding, Celsius, calibrated humidity
		ahb(1'b0, {24'h0, A_STAT}, 32'h0);
		check(rd, {16'h03c0 + hc, 16'h000d});
		print_verdict();
	end
endmodule : testbench
